// ==== verilog/priority_irq_unit.sv ====
// prioritized interrupt unit with gpio and down-counting timer
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module priority_irq_unit
  import piu_pkg::*;
#(
  parameter int NIRQ = 16,
  parameter int NPIN = 32
)(
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  // external interrupt sources, lines 2 and up
  input  wire logic [piu_pkg::NUM_IRQ-1:0] irq_src_in,
  // core side
  output logic                            core_irq_request_out,
  output logic                            core_halt_release_out,
  output logic [3:0]                      core_irq_addr_out,
  output logic                            irq_out,
  // gpio pins
  input  wire logic [piu_pkg::NUM_PIN-1:0] gpio_in,
  output logic [piu_pkg::NUM_PIN-1:0]     gpio_out,
  output logic [piu_pkg::NUM_PIN-1:0]     gpio_oe_n_out,
  // axi4-lite write
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  import piu_pkg::*;

  // ==========================================
  // registers
  logic [NIRQ-1:0] enable_mask;
  logic [NIRQ-1:0] run_mask;
  logic [NPIN-1:0] gp_dir;
  logic [NPIN-1:0] gp_out;
  logic [NPIN-1:0] gp_ien;
  logic [NPIN-1:0] gp_mode0;
  logic [NPIN-1:0] gp_mode1;
  logic [NPIN-1:0] gp_clr;
  logic [1:0]      tmr_ctrl;
  logic [31:0]     tmr_load;
  logic [31:0]     tmr_cnt;
  logic [EV_W-1:0] ev_stat;
  logic [EV_W-1:0] ev_en;
  logic [NIRQ-1:0] sync1;
  logic [NIRQ-1:0] sync2;
  logic            tmr_irq;

  piu_gpio_if #(.N(NPIN)) gif ();

  // ==========================================
  // gpio detector
  assign gif.pins   = gpio_in;
  assign gif.irq_en = gp_ien & ~gp_dir;
  assign gif.mode0  = gp_mode0;
  assign gif.mode1  = gp_mode1;
  assign gif.clr    = gp_clr;

  piu_gpio_detect #(.N(NPIN)) u_det (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .g         (gif.det)
  );

  // ==========================================
  // raw sources: gpio and timer on fixed lines
  logic [NIRQ-1:0] raw_src;
  logic            gpio_any;
  logic            tmr_zero;
  logic            tmr_run;
  assign gpio_any = |gif.stat;
  assign tmr_zero = (tmr_cnt == RST_ZERO);
  assign tmr_run  = tmr_ctrl[TMR_RUN_BIT];

  always_comb
  begin
    raw_src             = irq_src_in;
    raw_src[LINE_GPIO]  = gpio_any;
    raw_src[LINE_TIMER] = tmr_irq;
  end

  // ==========================================
  // priority encoder, lowest index wins
  function automatic logic [4:0] first_set(input logic [NIRQ-1:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int k = NIRQ - 1; k >= 0; k--)
      if (v[k])
        r = 5'(k);
    return r;
  endfunction

  logic [NIRQ-1:0] active;
  logic [4:0]      win;
  logic            any_req;
  assign active  = sync2 & enable_mask;
  assign win     = first_set(active);
  assign any_req = ~win[4];

  // ==========================================
  // axi4-lite slave
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_ok;
  logic [31:0] merged;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [31:0] cur;

  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;

  always_comb
  begin
    cur = RST_ZERO;
    unique case (aw_addr)
      OFF_ENABLE:   cur = 32'(enable_mask);
      OFF_RUN:      cur = 32'(run_mask);
      OFF_GP_DIR:   cur = gp_dir;
      OFF_GP_OUT:   cur = gp_out;
      OFF_GP_IEN:   cur = gp_ien;
      OFF_GP_MODE0: cur = gp_mode0;
      OFF_GP_MODE1: cur = gp_mode1;
      OFF_TMR_CTRL: cur = 32'(tmr_ctrl);
      OFF_TMR_LOAD: cur = tmr_load;
      OFF_EV_EN:    cur = 32'(ev_en);
      default:      cur = RST_ZERO;
    endcase
  end

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
      assign merged[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : cur[b*8 +: 8];
    end
  endgenerate

  assign wr_ok = (aw_addr <= OFF_EV_CLR) && (aw_addr[1:0] == 2'b00)
                 && (aw_addr != OFF_PENDING) && (aw_addr != OFF_VECTOR)
                 && (aw_addr != OFF_GP_IN) && (aw_addr != OFF_GP_STAT)
                 && (aw_addr != OFF_TMR_CNT) && (aw_addr != OFF_EV_STAT);

  always_comb
  begin
    rd_val = RST_ZERO;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      OFF_ENABLE:   rd_val = 32'(enable_mask);
      OFF_RUN:      rd_val = 32'(run_mask);
      OFF_PENDING:  rd_val = 32'(sync2);
      OFF_VECTOR:   rd_val = {26'h0, any_req, win};
      OFF_GP_DIR:   rd_val = gp_dir;
      OFF_GP_OUT:   rd_val = gp_out;
      OFF_GP_IN:    rd_val = gpio_in;
      OFF_GP_IEN:   rd_val = gp_ien;
      OFF_GP_MODE0: rd_val = gp_mode0;
      OFF_GP_MODE1: rd_val = gp_mode1;
      OFF_GP_STAT:  rd_val = gif.stat;
      OFF_GP_CLR:   rd_val = RST_ZERO;
      OFF_TMR_CTRL: rd_val = 32'(tmr_ctrl);
      OFF_TMR_LOAD: rd_val = tmr_load;
      OFF_TMR_CNT:  rd_val = tmr_cnt;
      OFF_EV_STAT:  rd_val = 32'(ev_stat);
      OFF_EV_EN:    rd_val = 32'(ev_en);
      OFF_EV_CLR:   rd_val = RST_ZERO;
      default:      rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= RST_ZERO;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= RST_ZERO;
    end
    else
    begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // register writes, timer and core outputs
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic            tmr_wrap;
  assign tmr_wrap = tmr_run & tmr_zero;
  assign ev_set   = {gpio_any, tmr_wrap};
  assign ev_clr   = (do_write && aw_addr == OFF_EV_CLR) ? merged[EV_W-1:0] : '0;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      enable_mask           <= '0;
      run_mask              <= '0;
      gp_dir                <= '0;
      gp_out                <= '0;
      gp_ien                <= '0;
      gp_mode0              <= '0;
      gp_mode1              <= '0;
      gp_clr                <= '0;
      tmr_ctrl              <= '0;
      tmr_load              <= RST_TMR;
      tmr_cnt               <= RST_TMR;
      tmr_irq               <= 1'b0;
      ev_stat               <= '0;
      ev_en                 <= '0;
      sync1                 <= '0;
      sync2                 <= '0;
      core_irq_request_out  <= 1'b0;
      core_halt_release_out <= 1'b0;
      core_irq_addr_out     <= '0;
      irq_out               <= 1'b0;
      gpio_out              <= '0;
      gpio_oe_n_out         <= '1;
    end
    else
    begin
      sync1  <= raw_src;
      sync2  <= sync1;
      gp_clr <= '0;
      if (do_write)
      begin
        unique case (aw_addr)
          OFF_ENABLE:   enable_mask <= merged[NIRQ-1:0];
          OFF_RUN:      run_mask    <= merged[NIRQ-1:0];
          OFF_GP_DIR:   gp_dir      <= merged;
          OFF_GP_OUT:   gp_out      <= merged;
          OFF_GP_IEN:   gp_ien      <= merged;
          OFF_GP_MODE0: gp_mode0    <= merged;
          OFF_GP_MODE1: gp_mode1    <= merged;
          OFF_GP_CLR:   gp_clr      <= merged;
          OFF_TMR_CTRL: tmr_ctrl    <= merged[1:0];
          OFF_TMR_LOAD: tmr_load    <= merged;
          OFF_EV_EN:    ev_en       <= merged[EV_W-1:0];
          default:      ;
        endcase
      end
      // the timer reload never touches load or control
      if (do_write && aw_addr == OFF_TMR_LOAD)
        tmr_cnt <= merged;
      else if (tmr_wrap)
        tmr_cnt <= tmr_load;
      else if (tmr_run)
        tmr_cnt <= tmr_cnt - 32'h0000_0001;
      // sticky until cleared via the timer status bit; set wins
      if (tmr_wrap && tmr_ctrl[TMR_IRQ_BIT])
        tmr_irq <= 1'b1;
      else if (ev_clr[EV_TIMER_BIT])
        tmr_irq <= 1'b0;
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
      irq_out <= |(((ev_stat & ~ev_clr) | ev_set) & ev_en);
      core_irq_request_out  <= any_req;
      core_irq_addr_out     <= win[3:0];
      core_halt_release_out <= any_req & run_mask[win[3:0]];
      gpio_out      <= gp_out;
      gpio_oe_n_out <= ~gp_dir;
    end
  end
endmodule

// ==== shared/piu_pkg.sv ====
// package of constants and types for the prioritized interrupt unit
// ==========================================
// How it works
// - every source passes a two-flop synchroniser
// - sixteen interrupt lines, numbered zero to fifteen
// - lowest numbered enabled pending line wins
// - interrupt address equals winning line number
// - enable mask gates the core request
// - run mask gates the halt release
// - thirty-two pins: output, input, interrupt input
// - rising, falling, low or high trigger
// - trigger chosen per pin
// - all pin interrupts share one line
// - timer counts down while enabled
// - at zero reload and maybe interrupt
package piu_pkg;
  localparam int NUM_IRQ  = 16;
  localparam int NUM_PIN  = 32;
  localparam int ADDR_W   = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ENABLE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RUN      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PENDING  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_VECTOR   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_GP_DIR   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_GP_OUT   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_GP_IN    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_GP_IEN   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_GP_MODE0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_GP_MODE1 = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_GP_STAT  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_GP_CLR   = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_TMR_CTRL = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_TMR_LOAD = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_TMR_CNT  = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_EV_STAT  = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_EV_EN    = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_EV_CLR   = 8'h44;
  // fixed line numbers of the built-in sources
  localparam int LINE_GPIO  = 0;
  localparam int LINE_TIMER = 1;
  // timer control fields
  localparam int TMR_RUN_BIT = 0;
  localparam int TMR_IRQ_BIT = 1;
  // event status fields
  localparam int EV_TIMER_BIT = 0;
  localparam int EV_GPIO_BIT  = 1;
  localparam int EV_W         = 2;
  // reset values and axi response codes
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_TMR    = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLERR = 2'b10;
  // gpio trigger: {mode1,mode0} per pin
  typedef enum logic [1:0] {PIU_TRIG_LOW, PIU_TRIG_HIGH, PIU_TRIG_RISE, PIU_TRIG_FALL} piu_trig_e;
endpackage

// ==== shared/piu_gpio_if.sv ====
// interface between the unit and its gpio detector
`timescale 1ns/1ps
interface piu_gpio_if #(parameter int N = 32);
  logic [N-1:0] pins;
  logic [N-1:0] irq_en;
  logic [N-1:0] mode0;
  logic [N-1:0] mode1;
  logic [N-1:0] clr;
  logic [N-1:0] stat;
  modport ctrl (output pins, irq_en, mode0, mode1, clr, input stat);
  modport det  (input pins, irq_en, mode0, mode1, clr, output stat);
endinterface

// ==== verilog/piu_gpio_detect.sv ====
// per pin gpio interrupt detection
`timescale 1ns/1ps
module piu_gpio_detect
  import piu_pkg::*;
#(
  parameter int N = 32
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // detector side
  piu_gpio_if.det   g
);
  logic [N-1:0] prev;
  logic [N-1:0] edge_stat;
  logic [N-1:0] level_hit;
  logic [N-1:0] edge_hit;
  logic [N-1:0] is_edge;

  // ==========================================
  // trigger selection, one generate slice per pin
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pin
      assign is_edge[i]   = g.mode1[i];
      assign edge_hit[i]  = g.mode0[i] ? (prev[i] & ~g.pins[i])
                                       : (~prev[i] & g.pins[i]);
      assign level_hit[i] = g.mode0[i] ? g.pins[i] : ~g.pins[i];
      // levels follow the pin; edges are sticky
      assign g.stat[i]    = g.irq_en[i] & (is_edge[i] ? edge_stat[i] : level_hit[i]);
    end
  endgenerate

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      prev      <= '0;
      edge_stat <= '0;
    end
    else
    begin
      prev      <= g.pins;
      // set wins over clear
      edge_stat <= (edge_stat & ~g.clr) | (edge_hit & is_edge & g.irq_en);
    end
  end
endmodule

// ==== verif/piu_core_model.sv ====
// behavioural core that takes prioritized interrupt requests
`timescale 1ns/1ps
module piu_core_model
(
  // clock
  input  wire logic       clk_in,
  // requests from the unit
  input  wire logic       request_in,
  input  wire logic       release_in,
  input  wire logic [3:0] addr_in,
  // what the core took
  output logic [3:0]      taken_addr_out,
  output logic            woke_out
);
  // ==========================================
  // acceptance
  // the core latches the vector on the same edge that samples the request, like a real fetch
  always @(posedge clk_in)
  begin
    if (request_in)
    begin
      taken_addr_out <= addr_in;
      woke_out       <= release_in;
    end
  end
endmodule

// ==== verif/piu_sva.sv ====
// port assertions for the prioritized interrupt unit
`timescale 1ns/1ps
module piu_sva
  import piu_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // watched ports
  input  wire logic [15:0] irq_src_in,
  input  wire logic        core_irq_request_out,
  input  wire logic        core_halt_release_out,
  input  wire logic [3:0]  core_irq_addr_out,
  input  wire logic [31:0] gpio_oe_n_out,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================
  // source history, two sync flops plus the output flop
  logic [15:0] src_d1;
  logic [15:0] src_d2;
  logic [15:0] src_d3;
  always_ff @(posedge clk_in)
  begin
    src_d1 <= irq_src_in;
    src_d2 <= src_d1;
    src_d3 <= src_d2;
  end
  // ==========================================
  // assertions
  AST_SRC_TO_VECTOR: assert property (core_irq_request_out
    && core_irq_addr_out > 4'h1 |-> src_d3[core_irq_addr_out])
    else $error("vector names a line that was not pending");
  AST_OE_RESET: assert property ($rose(resetn_in) |-> gpio_oe_n_out == 32'hffff_ffff)
    else $error("pins driven right after reset");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  // only a joint handshake bounds the answer; a late data beat may delay it freely
  AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid) else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_SLERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  AST_HALT_REQ: assert property (core_halt_release_out |-> core_irq_request_out)
    else $error("halt release without a request");
  cover property (core_irq_request_out && core_irq_addr_out == 4'h0);
  cover property (core_irq_request_out && core_irq_addr_out == 4'h1);
  cover property (core_halt_release_out);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLERR);
endmodule

bind priority_irq_unit piu_sva u_sva (.*);

// ==== verif/tb_top.sv ====
// self-checking testbench for the prioritized interrupt unit
`timescale 1ns/1ps
module tb_top;
  import piu_pkg::*;
  logic        clk_in;
  logic        resetn_in;
  logic [15:0] irq_src_in;
  logic        core_irq_request_out;
  logic        core_halt_release_out;
  logic [3:0]  core_irq_addr_out;
  logic        irq_out;
  logic [31:0] gpio_in;
  logic [31:0] gpio_out;
  logic [31:0] gpio_oe_n_out;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [3:0]  taken;
  logic        woke;
  int          fail_count;
  int          checks_done;

  priority_irq_unit DUT (.*);
  piu_core_model core (.clk_in(clk_in), .request_in(core_irq_request_out),
    .release_in(core_halt_release_out), .addr_in(core_irq_addr_out),
    .taken_addr_out(taken), .woke_out(woke));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && n < 50)
    begin
      @(posedge clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end
    r = s_axi_bresp;
    if (n >= 50) fail_count++;
    s_axi_bready <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    while (!s_axi_rvalid && n < 50)
    begin
      @(posedge clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) fail_count++;
    s_axi_rready <= 1'b0;
    @(posedge clk_in);
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    chk(gpio_oe_n_out, 32'hffff_ffff);
    rd(OFF_TMR_CNT, d, r);
    chk(d, RST_TMR);
    rd(8'h80, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLERR));
    wr(OFF_PENDING, 32'h1, r);
    chk(32'(r), 32'(RESP_SLERR));
    wr(OFF_GP_DIR, 32'h1, r);
    wr(OFF_GP_OUT, 32'h1, r);
    repeat (2) @(posedge clk_in);
    chk(32'({gpio_oe_n_out[0], gpio_out[0]}), 32'h1);
  endtask
  task automatic t_prio();
    logic [1:0] r;
    wr(OFF_ENABLE, 32'hfdff, r);
    wr(OFF_RUN, 32'h0400, r);
    for (int i = 2; i < 16; i++)
    begin
      irq_src_in <= 16'h1 << i;
      repeat (4) @(posedge clk_in);
      chk(32'({core_irq_request_out, core_halt_release_out, i == 9 ? 4'(i) : core_irq_addr_out}),
        32'({i != 9, i == 10, 4'(i)}));
    end
    irq_src_in <= 16'h8624;
    repeat (4) @(posedge clk_in);
    chk(32'({core_irq_request_out, core_irq_addr_out}), 32'h12);
    irq_src_in <= 16'h8600;
    repeat (5) @(posedge clk_in);
    chk(32'({woke, taken}), 32'h1a);
    irq_src_in <= 16'h0;
  endtask
  task automatic t_gpio();
    logic [31:0] d;
    logic [1:0]  r;
    logic        idle;
    wr(OFF_GP_IEN, 32'h8, r);
    wr(OFF_ENABLE, 32'h1, r);
    wr(OFF_EV_EN, 32'h2, r);
    for (int m = 0; m < 4; m++)
    begin
      idle = (m == 0 || m == 3);
      gpio_in[3] <= idle;
      wr(OFF_GP_MODE0, 32'(m % 2) << 3, r);
      wr(OFF_GP_MODE1, 32'(m / 2) << 3, r);
      wr(OFF_GP_CLR, 32'h8, r);
      wr(OFF_EV_CLR, 32'h2, r);
      rd(OFF_GP_STAT, d, r);
      chk(d, 32'h0);
      gpio_in[3] <= !idle;
      repeat (5) @(posedge clk_in);
      rd(OFF_GP_STAT, d, r);
      chk(d, 32'h8);
      chk(32'({irq_out, core_irq_request_out, core_irq_addr_out}), 32'h30);
      gpio_in[3] <= idle;
      repeat (5) @(posedge clk_in);
      rd(OFF_GP_STAT, d, r);
      chk(d, m > 1 ? 32'h8 : 32'h0);
    end
  endtask
  task automatic t_timer();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_TMR_CTRL, 32'h0, r);
    wr(OFF_TMR_LOAD, 32'h5, r);
    wr(OFF_ENABLE, 32'h2, r);
    wr(OFF_EV_EN, 32'h1, r);
    wr(OFF_EV_CLR, 32'h3, r);
    rd(OFF_TMR_CNT, d, r);
    chk(d, 32'h5);
    rd(OFF_TMR_CNT, d, r);
    chk(d, 32'h5);
    // running with the interrupt bit off: wraps are counted as events only
    wr(OFF_TMR_CTRL, 32'h1, r);
    repeat (12) @(posedge clk_in);
    wr(OFF_TMR_CTRL, 32'h0, r);
    repeat (3) @(posedge clk_in);
    chk(32'({irq_out, core_irq_request_out}), 32'h2);
    wr(OFF_EV_CLR, 32'h1, r);
    wr(OFF_TMR_CTRL, 32'h3, r);
    repeat (12) @(posedge clk_in);
    wr(OFF_TMR_CTRL, 32'h0, r);
    rd(OFF_TMR_LOAD, d, r);
    chk(d, 32'h5);
    rd(OFF_TMR_CNT, d, r);
    chk(32'(d <= 32'h5), 32'h1);
    repeat (3) @(posedge clk_in);
    chk(32'({irq_out, core_irq_request_out, core_irq_addr_out}), 32'h31);
    wr(OFF_EV_CLR, 32'h1, r);
    repeat (4) @(posedge clk_in);
    chk(32'({irq_out, core_irq_request_out}), 32'h0);
  endtask
  // ==========================================
  // run control
  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    resetn_in = 1'b0;
    irq_src_in = 16'h0;
    gpio_in = 32'h0;
    s_axi_awaddr = 8'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_prio();
    t_gpio();
    t_timer();
    wrap_up();
  end
endmodule
